// ---- pkg/irp_pkg.sv ----
// shared constants and types for the infrared remote pin port block
package irp_pkg;

  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] IRP_OFS_CTRL     = 8'h00;
  localparam logic [7:0] IRP_OFS_SCAN_OUT = 8'h04;
  localparam logic [7:0] IRP_OFS_CARRIER  = 8'h08;
  localparam logic [7:0] IRP_OFS_PIN_STAT = 8'h0C;
  localparam logic [7:0] IRP_OFS_PROG     = 8'h10;

  // control register layout, first field is the top bit
  typedef struct packed {
    logic prog_verify;     // bit 7: device drives the data bus in prog mode
    logic carrier_en;      // bit 6: emit carrier on the infrared output
    logic key_ret_pd_en;   // bit 5: pull-downs of the key return group
    logic wake_en;         // bit 4: stop release from the wake sense pin
    logic indicator_mode;  // bit 3: dual-role pin is the indicator output
    logic sense_a_in_en;   // bit 2: first sense pin in input mode
    logic sense_pd_en;     // bit 1: pull-downs of the two sense pins
    logic scan_out_en;     // bit 0: key scan port in output mode
  } irp_ctrl_t;

  // carrier phase widths, each in units of one oscillator period
  typedef struct packed {
    logic [7:0] low_w;     // bits 15:8
    logic [7:0] high_w;    // bits 7:0
  } irp_carrier_t;

  // reset values
  localparam irp_ctrl_t    IRP_CTRL_RST     = 8'h29;
  localparam logic [7:0]   IRP_SCAN_OUT_RST = 8'hFF;
  localparam irp_carrier_t IRP_CARRIER_RST  = 16'h0000;

  // positions of the pin inputs in the synchroniser vector
  localparam int IRP_PIN_SCAN_LSB = 0;
  localparam int IRP_PIN_RET_LSB  = 8;
  localparam int IRP_PIN_SENSE_A  = 12;
  localparam int IRP_PIN_SENSE_B  = 13;
  localparam int IRP_PIN_WAKE     = 14;
  localparam int IRP_PIN_PMODE    = 15;
  localparam int IRP_PIN_PCLK     = 16;
  localparam int IRP_PIN_NUM      = 17;

  // carrier timing: one width unit is one oscillator period
  localparam int IRP_CLK_PERIOD_PS   = 4000;
  localparam int IRP_CARRIER_UNIT_NS = 250;
  // least width, so the count rounds up to whole core cycles
  localparam int IRP_UNIT_CYC =
    (IRP_CARRIER_UNIT_NS * 1000 + IRP_CLK_PERIOD_PS - 1) / IRP_CLK_PERIOD_PS;

endpackage : irp_pkg

// ---- verilog/irp_pin_ports.sv ----
// pin-level port logic of the infrared remote transmitter controller
`timescale 1ns/1ps
`default_nettype none

module irp_pin_ports
  import irp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_B,
  // ahb-lite slave
  input  wire logic                  HSEL,
  input  wire logic [7:0]            HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic      [31:0]           HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  // key scan port, doubles as the programming data bus
  input  wire logic [7:0]            KEY_SCAN_I,
  output logic      [7:0]            KEY_SCAN_O,
  output logic                       KEY_SCAN_OE_B,
  output logic                       KEY_SCAN_PD,
  // first sense pin
  input  wire logic                  SENSE_A_I,
  output logic                       SENSE_A_PD,
  // dual-role sense / indicator pin
  input  wire logic                  SENSE_B_I,
  output logic                       SENSE_B_O,
  output logic                       SENSE_B_OE_B,
  output logic                       SENSE_B_PD,
  // wake sense pin
  input  wire logic                  WAKE_I,
  output logic                       WAKE_PD,
  output logic                       STOP_RELEASE,
  // key return port
  input  wire logic [3:0]            KEY_RET_I,
  output logic                       KEY_RET_PD,
  // infrared carrier output
  output logic                       IR_CARRIER_OUT,
  // programming mode pins
  input  wire logic                  PROG_MODE,
  input  wire logic                  PROG_CLK,
  output logic      [ADDR_W-1:0]     PROG_ADDR
);
  import irp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // register decode shared by the read and write paths

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      IRP_OFS_CTRL:     reg_index = 3'h1;
      IRP_OFS_SCAN_OUT: reg_index = 3'h2;
      IRP_OFS_CARRIER:  reg_index = 3'h3;
      IRP_OFS_PIN_STAT: reg_index = 3'h4;
      IRP_OFS_PROG:     reg_index = 3'h5;
      default:          reg_index = 3'h0;
    endcase
  endfunction : reg_index

  // last cycle of a phase lasting (w+1) oscillator periods
  function automatic logic [14:0] width_term(input logic [7:0] w);
    logic [15:0] prod;
    prod = (16'(w) + 16'h0001) * 16'(IRP_UNIT_CYC);
    width_term = 15'(prod - 16'h0001);
  endfunction : width_term

  irp_ctrl_t               ctrl_q;
  irp_carrier_t            carrier_q;
  logic [7:0]              scan_out_q;
  logic                    wr_pend_q;
  logic [7:0]              wr_addr_q;
  logic [31:0]             hrdata_q;
  logic                    hreadyout_q;
  logic [IRP_PIN_NUM-1:0]  pin_raw;
  logic [IRP_PIN_NUM-1:0]  s1_q;
  logic [IRP_PIN_NUM-1:0]  s2_q;
  logic [IRP_PIN_NUM-1:0]  s3_q;
  logic [IRP_PIN_NUM-1:0]  filt_q;
  logic                    pclk_prev_q;
  logic [ADDR_W-1:0]       prog_addr_q;
  logic                    run_q;
  logic                    ir_q;
  logic [14:0]             cnt_q;
  logic                    addr_ph;
  logic                    prog_mode;
  logic                    pclk_rise;
  logic                    carrier_go;
  logic [7:0]              scan_o_q;
  logic                    scan_oe_b_q;
  logic                    scan_pd_q;
  logic                    sa_pd_q;
  logic                    sb_o_q;
  logic                    sb_oe_b_q;
  logic                    sb_pd_q;
  logic                    wake_pd_q;
  logic                    stop_rel_q;
  logic                    ret_pd_q;
  logic [31:0]             rd_word;

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay

  assign addr_ph = HSEL & HTRANS[1] & HREADY;

  // address phase captured for the write that follows in the data phase
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ph & HWRITE;
      wr_addr_q <= HADDR;
    end
  end

  // read mux; unmapped offsets and reserved bits read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (reg_index(HADDR))
      3'h1: rd_word[7:0]  = ctrl_q;
      3'h2: rd_word[7:0]  = scan_out_q;
      3'h3: rd_word[15:0] = carrier_q;
      3'h4:
      begin
        rd_word[7:0]  = filt_q[IRP_PIN_SCAN_LSB +: 8];
        rd_word[11:8] = filt_q[IRP_PIN_RET_LSB +: 4];
        // off mode: the input buffer is cut, so the pin reads low
        rd_word[12]   = filt_q[IRP_PIN_SENSE_A] & ctrl_q.sense_a_in_en;
        rd_word[13]   = filt_q[IRP_PIN_SENSE_B];
        rd_word[14]   = filt_q[IRP_PIN_WAKE];
      end
      3'h5:
      begin
        rd_word[ADDR_W-1:0] = prog_addr_q;
        rd_word[16]         = prog_mode;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data is registered in the address phase so it stands in the data
  // phase; a read right after a write to the same word sees the old value
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      hrdata_q    <= (addr_ph & !HWRITE) ? rd_word : 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
  end

  // register writes in the data phase
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      ctrl_q     <= IRP_CTRL_RST;
      scan_out_q <= IRP_SCAN_OUT_RST;
      carrier_q  <= IRP_CARRIER_RST;
    end
    else if (wr_pend_q)
    begin
      case (reg_index(wr_addr_q))
        3'h1:    ctrl_q     <= HWDATA[7:0];
        3'h2:    scan_out_q <= HWDATA[7:0];
        3'h3:    carrier_q  <= HWDATA[15:0];
        default: ctrl_q     <= ctrl_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin input synchronisers: three stages, a change counts once the second
  // and third stages agree, which also drops single-cycle glitches

  assign pin_raw = {PROG_CLK, PROG_MODE, WAKE_I, SENSE_B_I, SENSE_A_I,
                    KEY_RET_I, KEY_SCAN_I};

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per-bit agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < IRP_PIN_NUM; gi++)
    begin : g_filt
      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_B)
          filt_q[gi] <= 1'b0;
        else if (s2_q[gi] == s3_q[gi])
          filt_q[gi] <= s2_q[gi];
      end
    end
  endgenerate

  assign prog_mode = filt_q[IRP_PIN_PMODE];
  assign pclk_rise = filt_q[IRP_PIN_PCLK] & !pclk_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // programming mode address counter

  // address restarts at zero on each entry into programming mode
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      pclk_prev_q <= 1'b0;
      prog_addr_q <= '0;
    end
    else
    begin
      pclk_prev_q <= filt_q[IRP_PIN_PCLK];
      if (!prog_mode)
        prog_addr_q <= '0;
      else if (pclk_rise)
        prog_addr_q <= prog_addr_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // carrier generator: high phase first, widths compared against the register every cycle

  assign carrier_go = ctrl_q.carrier_en & !prog_mode;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      run_q <= 1'b0;
      ir_q  <= 1'b0;
      cnt_q <= 15'h0000;
    end
    else if (!carrier_go)
    begin
      run_q <= 1'b0;
      ir_q  <= 1'b0;
      cnt_q <= 15'h0000;
    end
    else if (!run_q)
    begin
      run_q <= 1'b1;
      ir_q  <= 1'b1;
      cnt_q <= 15'h0000;
    end
    // at or past the end: a width lowered mid-phase ends the phase at once
    // instead of letting the count run round the whole counter
    else if (cnt_q >= width_term(ir_q ? carrier_q.high_w
                                      : carrier_q.low_w))
    begin
      ir_q  <= !ir_q;
      cnt_q <= 15'h0000;
    end
    else
      cnt_q <= cnt_q + 15'h0001;
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered; enables are low while driving

  // key scan port: one direction for all eight pins, or the prog data bus
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      scan_o_q    <= IRP_SCAN_OUT_RST;
      scan_oe_b_q <= 1'b0;
      scan_pd_q   <= 1'b0;
    end
    else if (prog_mode)
    begin
      scan_o_q    <= scan_out_q;
      scan_oe_b_q <= !ctrl_q.prog_verify;
      scan_pd_q   <= 1'b0;
    end
    else
    begin
      scan_o_q    <= scan_out_q;
      scan_oe_b_q <= !ctrl_q.scan_out_en;
      scan_pd_q   <= !ctrl_q.scan_out_en;
    end
  end

  // sense pins: the shared pull-down bit only acts on pins in input mode
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      sa_pd_q   <= 1'b0;
      sb_o_q    <= 1'b1;
      sb_oe_b_q <= 1'b0;
      sb_pd_q   <= 1'b0;
    end
    else
    begin
      sa_pd_q   <= ctrl_q.sense_pd_en & ctrl_q.sense_a_in_en;
      sb_pd_q   <= ctrl_q.sense_pd_en & !ctrl_q.indicator_mode;
      sb_oe_b_q <= !ctrl_q.indicator_mode;
      // low for the whole burst, switched on the same edge as the carrier
      sb_o_q    <= !carrier_go;
    end
  end

  // wake pin: pull-down and stop release only while wake is enabled
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      wake_pd_q  <= 1'b0;
      stop_rel_q <= 1'b0;
      ret_pd_q   <= IRP_CTRL_RST.key_ret_pd_en;
    end
    else
    begin
      wake_pd_q  <= ctrl_q.wake_en;
      stop_rel_q <= ctrl_q.wake_en & filt_q[IRP_PIN_WAKE];
      ret_pd_q   <= ctrl_q.key_ret_pd_en;
    end
  end

  assign HRDATA         = hrdata_q;
  assign HREADYOUT      = hreadyout_q;
  assign HRESP          = 1'b0;
  assign KEY_SCAN_O     = scan_o_q;
  assign KEY_SCAN_OE_B  = scan_oe_b_q;
  assign KEY_SCAN_PD    = scan_pd_q;
  assign SENSE_A_PD     = sa_pd_q;
  assign SENSE_B_O      = sb_o_q;
  assign SENSE_B_OE_B   = sb_oe_b_q;
  assign SENSE_B_PD     = sb_pd_q;
  assign WAKE_PD        = wake_pd_q;
  assign STOP_RELEASE   = stop_rel_q;
  assign KEY_RET_PD     = ret_pd_q;
  assign IR_CARRIER_OUT = ir_q;
  assign PROG_ADDR      = prog_addr_q;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  // cycles the infrared output has stood high, for the width check
  logic [14:0] hi_len_q;
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || !ir_q)
      hi_len_q <= 15'h0000;
    else
      hi_len_q <= hi_len_q + 15'h0001;
  end

  a_scan_dir_pd: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (!prog_mode && !ctrl_q.scan_out_en) |=>
      KEY_SCAN_OE_B && KEY_SCAN_PD)
    else $error("key scan port not an input with pull-down");

  a_sense_pd_group: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(ctrl_q.sense_pd_en) && ctrl_q.sense_a_in_en
      && !ctrl_q.indicator_mode |=> SENSE_A_PD && SENSE_B_PD)
    else $error("sense pull-downs did not follow the group bit");

  a_sense_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !ctrl_q.sense_a_in_en [*2] |-> !SENSE_A_PD)
    else $error("off-mode sense pin still pulled down");

  a_ind_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (IR_CARRIER_OUT && !SENSE_B_OE_B) |-> !SENSE_B_O)
    else $error("indicator not low while carrier is emitted");

  a_carrier_start: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(run_q) |-> IR_CARRIER_OUT && !$past(IR_CARRIER_OUT))
    else $error("carrier did not start with a high phase");

  a_high_width: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ir_q && $stable(carrier_q.high_w) && carrier_go) |->
      hi_len_q <= width_term(carrier_q.high_w))
    else $error("carrier high phase longer than programmed");

  a_phase_flip: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (run_q && carrier_go && !ir_q
      && cnt_q == width_term(carrier_q.low_w)) |=> ir_q)
    else $error("low phase did not end at its programmed width");

  a_wake_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !ctrl_q.wake_en |=> !STOP_RELEASE && !WAKE_PD)
    else $error("wake pin active while wake is disabled");

  a_ret_pd: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $changed(ctrl_q.key_ret_pd_en) |=> KEY_RET_PD == $past(ctrl_q.key_ret_pd_en))
    else $error("key return pull-downs did not follow the group bit");

  a_prog_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (prog_mode && ctrl_q.prog_verify) ##1 (prog_mode && ctrl_q.prog_verify)
      |-> !KEY_SCAN_OE_B && KEY_SCAN_O == $past(scan_out_q))
    else $error("verify byte not driven on the data bus");

  a_prog_step: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (prog_mode && pclk_rise) |=> PROG_ADDR == $past(PROG_ADDR) + 1'b1)
    else $error("program address did not step on the clock");

  a_reset_state: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !$past(RST_B) |-> KEY_SCAN_O == 8'hFF && !KEY_SCAN_OE_B && !IR_CARRIER_OUT
      && SENSE_B_O && !SENSE_B_OE_B && !WAKE_PD && !STOP_RELEASE)
    else $error("outputs not at their reset state");

endmodule : irp_pin_ports
`default_nettype wire

// ---- verif/irp_partner.sv ----
// partner model: key matrix lines, key return lines and prom programmer
`timescale 1ns/1ps
`default_nettype none

module irp_partner
(
  input  wire logic       clk,
  input  wire logic [7:0] scan_o,
  input  wire logic       scan_oe_b,
  input  wire logic       scan_pd,
  input  wire logic [7:0] key_press,
  output logic      [7:0] scan_i,
  input  wire logic       ret_pd,
  input  wire logic [3:0] ret_press,
  output logic      [3:0] ret_i,
  output logic            prog_mode,
  output logic            prog_clk
);
  logic [7:0] prog_data   = 8'h00;
  logic [7:0] scan_last_q = 8'h00;
  logic [3:0] ret_last_q  = 4'h0;

  initial
  begin
    prog_mode = 1'b0;
    prog_clk  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // floating lines show the inverse of their last level, so a stale
  // value can never pass for a driven one
  always @(posedge clk)
  begin
    scan_last_q <= scan_i;
    ret_last_q  <= ret_i;
  end

  // device drive wins, then the programmer, then keys over pull-downs
  assign scan_i = !scan_oe_b ? scan_o
                : prog_mode ? prog_data
                : scan_pd ? key_press : (key_press | ~scan_last_q);
  // return lines only float where the group pull-down is off
  assign ret_i = ret_press | (ret_pd ? 4'h0 : ~ret_last_q);

  ////////////////////////////////////////////////////////////////////////////
  // programmer: mode pin and the byte it offers while the device listens
  task automatic prog_set(input logic m, input logic [7:0] d);
    @(posedge clk);
    prog_data <= d;
    prog_mode <= m;
  endtask : prog_set

  // each clock phase held 6 cycles, above the 2 the filter needs
  task automatic prog_step(input int n);
    repeat (n)
    begin
      repeat (6) @(posedge clk);
      prog_clk <= 1'b1;
      repeat (6) @(posedge clk);
      prog_clk <= 1'b0;
    end
  endtask : prog_step
endmodule : irp_partner

`default_nettype wire

// ---- verif/ir_remote_pin_ports_tb.sv ----
// self-checking testbench of the infrared remote pin port block
`timescale 1ns/1ps
`default_nettype none

module ir_remote_pin_ports_tb;
  import irp_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  key_press = 8'h00;
  // key return lines stay low as reset ends
  logic [3:0]  ret_press = 4'h0;
  logic        sense_a_i = 1'b0;
  logic        sense_b_drv = 1'b0;
  logic        wake_i = 1'b1;
  logic [31:0] hrdata;
  logic [11:0] prog_addr;
  logic [7:0]  key_scan_i, key_scan_o;
  logic [3:0]  key_ret_i;
  logic        hreadyout, hresp, key_scan_oe_b, key_scan_pd, sense_a_pd;
  logic        sense_b_o, sense_b_oe_b, sense_b_pd, wake_pd, stop_release;
  logic        key_ret_pd, ir_carrier_out, prog_mode, prog_clk;
  wire logic   sense_b_i;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #2 core_clk = ~core_clk;
  // dual-role pin: device drive wins over the outside level
  assign sense_b_i = !sense_b_oe_b ? sense_b_o : sense_b_drv;

  irp_pin_ports dut (.CORE_CLK(core_clk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .KEY_SCAN_I(key_scan_i),
    .KEY_SCAN_O(key_scan_o), .KEY_SCAN_OE_B(key_scan_oe_b),
    .KEY_SCAN_PD(key_scan_pd), .SENSE_A_I(sense_a_i),
    .SENSE_A_PD(sense_a_pd), .SENSE_B_I(sense_b_i), .SENSE_B_O(sense_b_o),
    .SENSE_B_OE_B(sense_b_oe_b), .SENSE_B_PD(sense_b_pd), .WAKE_I(wake_i),
    .WAKE_PD(wake_pd), .STOP_RELEASE(stop_release), .KEY_RET_I(key_ret_i),
    .KEY_RET_PD(key_ret_pd), .IR_CARRIER_OUT(ir_carrier_out),
    .PROG_MODE(prog_mode), .PROG_CLK(prog_clk), .PROG_ADDR(prog_addr));

  irp_partner u_p (.clk(core_clk), .scan_o(key_scan_o),
    .scan_oe_b(key_scan_oe_b), .scan_pd(key_scan_pd),
    .key_press(key_press), .scan_i(key_scan_i), .ret_pd(key_ret_pd),
    .ret_press(ret_press), .ret_i(key_ret_i), .prog_mode(prog_mode),
    .prog_clk(prog_clk));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one single ahb-lite transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(a, 1'b1, d, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, exp,
                       input string what);
    logic [31:0] rd;
    ahb(a, 1'b0, 32'h0, rd);
    chk(what, rd & m, exp);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : rdchk

  // pin inputs pass three synchroniser flops and a filter flop, so allow 6 cycles to show
  task automatic settle;
    repeat (6) @(posedge core_clk);
  endtask : settle

  task automatic ctl(input logic [7:0] v);
    wr(IRP_OFS_CTRL, {24'h00_0000, v});
    settle();
  endtask : ctl

  // one full low and high phase after the partial first high phase,
  // indicator watched through both counted phases
  task automatic burst(input logic [15:0] cfg);
    int n_hi;
    int n_lo;
    int lit;
    n_hi = 0;
    n_lo = 0;
    lit = 0;
    wr(IRP_OFS_CARRIER, {16'h0000, cfg});
    ctl(8'h49);
    // the first high phase began during the settle after the write, so its start was missed
    while (ir_carrier_out === 1'b1) @(posedge core_clk);
    while (ir_carrier_out === 1'b0)
    begin
      n_lo++;
      lit += int'(sense_b_o !== 1'b0);
      @(posedge core_clk);
    end
    while (ir_carrier_out === 1'b1)
    begin
      n_hi++;
      lit += int'(sense_b_o !== 1'b0);
      @(posedge core_clk);
    end
    chk("high_w", n_hi, (cfg[7:0] + 1) * IRP_UNIT_CYC);
    chk("low_w", n_lo, (cfg[15:8] + 1) * IRP_UNIT_CYC);
    chk("led_lit", lit, 32'h0);
    ctl(8'h09);
    chk("ir_off", 32'(ir_carrier_out), 32'h0);
    chk("led_off", 32'(sense_b_o), 32'h1);
  endtask : burst

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // the longest burst needs about 16k cycles, so the ceiling is generous
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("scan_o", 32'(key_scan_o), 32'h0000_00FF);
    chk("scan_oe_b", 32'(key_scan_oe_b), 32'h0);
    chk("ir", 32'(ir_carrier_out), 32'h0);
    chk("led_oe_b", 32'(sense_b_oe_b), 32'h0);
    chk("led", 32'(sense_b_o), 32'h1);
    chk("wake_pd", 32'(wake_pd), 32'h0);
    chk("stop_rel", 32'(stop_release), 32'h0);
    rdchk(IRP_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0029, "ctrl");
    rdchk(IRP_OFS_SCAN_OUT, 32'hFFFF_FFFF, 32'h0000_00FF, "scan");
    rdchk(IRP_OFS_CARRIER, 32'hFFFF_FFFF, 32'h0, "carrier");
    wr(8'h14, 32'hFFFF_FFFF);
    rdchk(8'h14, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wr(IRP_OFS_SCAN_OUT, 32'h0000_005A);
    settle();
    chk("scan_o", 32'(key_scan_o), 32'h0000_005A);
    key_press <= 8'h81;
    ctl(8'h06);
    chk("scan_oe_b", 32'(key_scan_oe_b), 32'h1);
    chk("scan_pd", 32'(key_scan_pd), 32'h1);
    rdchk(IRP_OFS_PIN_STAT, 32'h0000_00FF, 32'h0000_0081, "keys");
    chk("sa_pd", 32'(sense_a_pd), 32'h1);
    chk("sb_pd", 32'(sense_b_pd), 32'h1);
    chk("led_oe_b", 32'(sense_b_oe_b), 32'h1);
    chk("ret_pd", 32'(key_ret_pd), 32'h0);
    chk("wake_pd", 32'(wake_pd), 32'h0);
    chk("stop_rel", 32'(stop_release), 32'h0);
    sense_a_i <= 1'b1;
    ret_press <= 4'h5;
    ctl(8'h34);
    chk("sa_pd", 32'(sense_a_pd), 32'h0);
    chk("wake_pd", 32'(wake_pd), 32'h1);
    chk("stop_rel", 32'(stop_release), 32'h1);
    chk("ret_pd", 32'(key_ret_pd), 32'h1);
    rdchk(IRP_OFS_PIN_STAT, 32'h0000_1F00, 32'h0000_1500, "ret");
    wake_i <= 1'b0;
    settle();
    chk("stop_rel", 32'(stop_release), 32'h0);
    // wake pin high again, but wake is off from here on
    wake_i <= 1'b1;
    ctl(8'h02);
    chk("sa_pd", 32'(sense_a_pd), 32'h0);
    rdchk(IRP_OFS_PIN_STAT, 32'h0000_1000, 32'h0, "sa_off");
    chk("stop_rel", 32'(stop_release), 32'h0);
    rdchk(IRP_OFS_PIN_STAT, 32'h0000_4000, 32'h0000_4000, "wake_pin");
    ctl(8'h09);
    chk("led_oe_b", 32'(sense_b_oe_b), 32'h0);
    chk("led", 32'(sense_b_o), 32'h1);
    burst(16'h0201);
    burst(16'hFF00);
    wr(IRP_OFS_SCAN_OUT, 32'h0000_003C);
    u_p.prog_set(1'b1, 8'h96);
    settle();
    chk("scan_oe_b", 32'(key_scan_oe_b), 32'h1);
    // the released bus takes the programmer byte, then passes the filter
    settle();
    rdchk(IRP_OFS_PIN_STAT, 32'h0000_00FF, 32'h0000_0096, "pdata");
    rdchk(IRP_OFS_PROG, 32'hFFFF_FFFF, 32'h0001_0000, "pmode");
    u_p.prog_step(3);
    settle();
    chk("paddr", 32'(prog_addr), 32'h3);
    ctl(8'h89);
    chk("scan_oe_b", 32'(key_scan_oe_b), 32'h0);
    chk("verify", 32'(key_scan_o), 32'h0000_003C);
    u_p.prog_set(1'b0, 8'h00);
    settle();
    chk("paddr", 32'(prog_addr), 32'h0);
    wrap_up();
  end
endmodule : ir_remote_pin_ports_tb

`default_nettype wire
